/* File: rtl/cjt_pkg.sv */
// What this block does
// - Tetrad compare uses full 24 bits
// - Tetrad compare is unsigned, every bit data
// - Tetrad compare flags: low 0011, equal 0100, high 1010
// - Masked compare checks only mask one bits
// - All checked bits one gives equal flags
// - Any checked bit zero gives high flags
// - Five-character instructions, sequential advance otherwise
// - Jump target is operand plus index register
// - Conditional jump taken when indicator is one
// - Indicators hold until written; testing keeps all but 40, 44, 57
// - Testing indicators 40, 44, 57 clears them
// - Jumps never touch accumulator registers
// - Selector codes 00-31 jump unconditionally
// - Selector codes 32 and 56 do nothing
// - Other codes 32-63 except 41, 42 jump on indicator one
// - Code 41 saves, 42 restores indicators 33-40 on the conditional jump; the return jump just advances
// - Loop count is six bits, max 63
// - Loop decrements first, jumps unless result zero
// - Loop count saturates at zero
// - Return jump stores counter plus five, continues after target
// - Substitution replaces 1 to 64 characters
// - Table address is row select and character
// - Characters and masks are six bits; tetrads are 24 bits
package cjt_pkg;
  localparam int CHAR_W = 6;
  localparam int ADDR_W = 15;
  localparam int INSTR_W = 30;
  localparam int TETRAD_W = 24;
  localparam int IND_W = 32;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;

  // Opcodes, upper five bits of the first character with a zero low bit
  localparam logic [5:0] OP_JR = 6'h08;
  localparam logic [5:0] OP_TR = 6'h0A;
  localparam logic [5:0] OP_LC = 6'h0C;
  localparam logic [5:0] OP_JC = 6'h18;
  localparam logic [5:0] OP_JL = 6'h1A;
  localparam logic [5:0] OP_CT = 6'h3C;

  // Indicator selector codes
  localparam logic [5:0] SEL_NOP_A = 6'h20;
  localparam logic [5:0] SEL_HIGH = 6'h21;
  localparam logic [5:0] SEL_EQUAL = 6'h22;
  localparam logic [5:0] SEL_UNEQUAL = 6'h23;
  localparam logic [5:0] SEL_LOW = 6'h24;
  localparam logic [5:0] SEL_DEC_OVF = 6'h28;
  localparam logic [5:0] SEL_SAVE = 6'h29;
  localparam logic [5:0] SEL_RESTORE = 6'h2A;
  localparam logic [5:0] SEL_OP_INT = 6'h2C;
  localparam logic [5:0] SEL_NOP_B = 6'h38;
  localparam logic [5:0] SEL_TRACE = 6'h39;

  localparam logic [ADDR_W-1:0] INSTR_STEP = 15'h0005;
  localparam logic [ADDR_W-1:0] LAST_CHAR_OFS = 15'h0004;
  localparam logic [6:0] TR_FULL_COUNT = 7'h40;

  // Register offsets on the plain register port
  localparam logic [BUS_AW-1:0] REG_IND = 8'h00;
  localparam logic [BUS_AW-1:0] REG_CC = 8'h04;
  localparam logic [BUS_AW-1:0] REG_INSTR = 8'h08;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [2:0] REG_INDEX_PAGE = 3'h1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_TAKEN_BIT = 1;

  localparam logic [IND_W-1:0] IND_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] CC_RST = 15'h0000;

  typedef enum logic [3:0] {
    CJT_IDLE = 4'h1,
    CJT_READ = 4'h2,
    CJT_WRITE = 4'h4,
    CJT_TAKE = 4'h8
  } cjt_state_e_t;
endpackage

/* File: rtl/cjt_unit.sv */
`timescale 1ns/1ps
module cjt_unit (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  // Character memory
  output logic [14:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [5:0] mem_wdata_out,
  input wire logic [5:0] mem_rdata_in,
  // Tetrad operands
  output logic [5:0] tetrad_sel_out,
  input wire logic [23:0] tetrad_data_in,
  input wire logic [5:0] table_row_select_in,
  // Status
  output logic busy_out
);
  typedef struct packed {
    cjt_pkg::cjt_state_e_t state;
    logic [31:0] ind;
    logic [14:0] cc;
    logic [29:0] instr;
    logic [14:0] ea;
    logic [6:0] step;
    logic [1:0] phase;
    logic [17:0] acc;
    logic taken;
    logic [7:1][14:0] index;
    logic mem_rd;
    logic mem_wr;
    logic [14:0] mem_addr;
    logic [5:0] mem_wdata;
    logic [31:0] bus_rdata;
  } cjt_regs_t;

  cjt_regs_t s_reg;
  cjt_regs_t s_next;

  // Loads the four comparison flags, high/equal/unequal/low
  function automatic logic [31:0] cjt_set_flags(input logic [31:0] ind, input logic [3:0] hel);
    logic [31:0] r;
    r = ind;
    r[cjt_pkg::SEL_HIGH[4:0]] = hel[3];
    r[cjt_pkg::SEL_EQUAL[4:0]] = hel[2];
    r[cjt_pkg::SEL_UNEQUAL[4:0]] = hel[1];
    r[cjt_pkg::SEL_LOW[4:0]] = hel[0];
    return r;
  endfunction

  logic [29:0] new_instr;
  logic [5:0] new_op;
  logic [5:0] cur_op;
  logic [5:0] sel;
  logic [14:0] index_val;
  logic [14:0] new_ea;
  logic start;
  logic cond_taken;
  logic is_nop;
  logic [5:0] loop_count;
  logic [23:0] mem_word;
  logic [14:0] ret_addr;
  logic [6:0] tr_count;
  logic [14:0] tr_addr;
  logic [5:0] masked;

  always_comb begin
    new_instr = bus_wdata_in[29:0];
    new_op = {new_instr[29:25], 1'b0};
    cur_op = {s_reg.instr[29:25], 1'b0};
    sel = new_instr[5:0];
    index_val = (new_instr[24:22] == 3'h0) ? 15'h0000 : s_reg.index[new_instr[24:22]];
    new_ea = new_instr[20:6] + index_val;
    start = bus_wr_in && (bus_addr_in == cjt_pkg::REG_INSTR) && (s_reg.state == cjt_pkg::CJT_IDLE);
    is_nop = (sel == cjt_pkg::SEL_NOP_A) || (sel == cjt_pkg::SEL_NOP_B);
    cond_taken = !sel[5] || (s_reg.ind[sel[4:0]] && !is_nop);
    loop_count = (new_instr[5:0] == 6'h00) ? 6'h00 : new_instr[5:0] - 6'h01;
    mem_word = {s_reg.acc, mem_rdata_in};
    ret_addr = s_reg.cc + cjt_pkg::INSTR_STEP;
    tr_count = (s_reg.instr[5:0] == 6'h00) ? cjt_pkg::TR_FULL_COUNT : {1'b0, s_reg.instr[5:0]};
    tr_addr = s_reg.ea - {8'h00, s_reg.step};
    masked = mem_rdata_in & s_reg.instr[5:0];
  end

  always_comb begin
    s_next = s_reg;
    s_next.mem_rd = 1'b0;
    s_next.mem_wr = 1'b0;
    s_next.bus_rdata = 32'h0000_0000;

    // Read answer stands for exactly one cycle; unmapped addresses read zero
    if (bus_rd_in) begin
      if (bus_addr_in == cjt_pkg::REG_IND) begin
        s_next.bus_rdata = s_reg.ind;
      end else if (bus_addr_in == cjt_pkg::REG_CC) begin
        s_next.bus_rdata = {17'h0_0000, s_reg.cc};
      end else if (bus_addr_in == cjt_pkg::REG_INSTR) begin
        s_next.bus_rdata = {2'h0, s_reg.instr};
      end else if (bus_addr_in == cjt_pkg::REG_STATUS) begin
        s_next.bus_rdata[cjt_pkg::STATUS_BUSY_BIT] = (s_reg.state != cjt_pkg::CJT_IDLE);
        s_next.bus_rdata[cjt_pkg::STATUS_TAKEN_BIT] = s_reg.taken;
      end else if (bus_addr_in[7:5] == cjt_pkg::REG_INDEX_PAGE && bus_addr_in[4:2] != 3'h0
                   && bus_addr_in[1:0] == 2'h0) begin
        s_next.bus_rdata = {17'h0_0000, s_reg.index[bus_addr_in[4:2]]};
      end
    end

    // Software writes go first so that hardware updates below win the same cycle
    if (bus_wr_in) begin
      if (bus_addr_in == cjt_pkg::REG_IND) begin
        s_next.ind = bus_wdata_in;
      end else if (bus_addr_in == cjt_pkg::REG_CC) begin
        s_next.cc = bus_wdata_in[14:0];
      end else if (bus_addr_in[7:5] == cjt_pkg::REG_INDEX_PAGE && bus_addr_in[4:2] != 3'h0
                   && bus_addr_in[1:0] == 2'h0) begin
        s_next.index[bus_addr_in[4:2]] = bus_wdata_in[14:0];
      end
    end

    case (s_reg.state)
      cjt_pkg::CJT_IDLE: begin
        if (start) begin
          s_next.instr = new_instr;
          s_next.ea = new_ea;
          s_next.step = 7'h00;
          s_next.phase = 2'h0;
          s_next.acc = 18'h0_0000;
          s_next.taken = 1'b0;
          s_next.mem_addr = new_ea;
          if (new_op == cjt_pkg::OP_CT || new_op == cjt_pkg::OP_LC || new_op == cjt_pkg::OP_TR) begin
            s_next.state = cjt_pkg::CJT_READ;
            s_next.mem_rd = 1'b1;
          end else if (new_op == cjt_pkg::OP_JC || new_op == cjt_pkg::OP_JR) begin
            // Only the tested indicator may change, and only for these three
            if (sel == cjt_pkg::SEL_DEC_OVF || sel == cjt_pkg::SEL_OP_INT || sel == cjt_pkg::SEL_TRACE) begin
              s_next.ind[sel[4:0]] = 1'b0;
            end
            if (new_op == cjt_pkg::OP_JC && sel == cjt_pkg::SEL_SAVE) begin
              s_next.state = cjt_pkg::CJT_WRITE;
              s_next.mem_wr = 1'b1;
              s_next.mem_wdata = s_reg.ind[6:1];
            end else if (new_op == cjt_pkg::OP_JC && sel == cjt_pkg::SEL_RESTORE) begin
              s_next.state = cjt_pkg::CJT_READ;
              s_next.mem_rd = 1'b1;
            end else if (!cond_taken || sel == cjt_pkg::SEL_SAVE || sel == cjt_pkg::SEL_RESTORE) begin
              s_next.cc = s_reg.cc + cjt_pkg::INSTR_STEP;
            end else if (new_op == cjt_pkg::OP_JC) begin
              s_next.cc = new_ea;
              s_next.taken = 1'b1;
            end else begin
              // Return jump patches the address field of the target first
              s_next.state = cjt_pkg::CJT_READ;
              s_next.mem_rd = 1'b1;
              s_next.mem_addr = new_ea + 15'h0001;
              s_next.taken = 1'b1;
            end
          end else if (new_op == cjt_pkg::OP_JL) begin
            // Decremented count goes back into the instruction's last character
            s_next.instr[5:0] = loop_count;
            s_next.state = cjt_pkg::CJT_WRITE;
            s_next.mem_wr = 1'b1;
            s_next.mem_addr = s_reg.cc + cjt_pkg::LAST_CHAR_OFS;
            s_next.mem_wdata = loop_count;
            s_next.taken = (loop_count != 6'h00);
          end else begin
            s_next.cc = s_reg.cc + cjt_pkg::INSTR_STEP;
          end
        end
      end

      cjt_pkg::CJT_READ: begin
        s_next.state = cjt_pkg::CJT_TAKE;
      end

      cjt_pkg::CJT_WRITE: begin
        s_next.state = cjt_pkg::CJT_TAKE;
      end

      cjt_pkg::CJT_TAKE: begin
        s_next.state = cjt_pkg::CJT_IDLE;
        if (cur_op == cjt_pkg::OP_CT) begin
          if (s_reg.step == 7'h03) begin
            // Plain unsigned magnitude compare of the whole 24-bit words
            // Flags are laid over this cycle's software write so its other bits survive
            if (tetrad_data_in < mem_word) begin
              s_next.ind = cjt_set_flags(s_next.ind, 4'h3);
            end else if (tetrad_data_in == mem_word) begin
              s_next.ind = cjt_set_flags(s_next.ind, 4'h4);
            end else begin
              s_next.ind = cjt_set_flags(s_next.ind, 4'hA);
            end
            s_next.cc = s_reg.cc + cjt_pkg::INSTR_STEP;
          end else begin
            s_next.acc = mem_word[17:0];
            s_next.step = s_reg.step + 7'h01;
            s_next.state = cjt_pkg::CJT_READ;
            s_next.mem_rd = 1'b1;
            s_next.mem_addr = s_reg.mem_addr + 15'h0001;
          end
        end else if (cur_op == cjt_pkg::OP_LC) begin
          if (masked == s_reg.instr[5:0]) begin
            s_next.ind = cjt_set_flags(s_next.ind, 4'h4);
          end else begin
            s_next.ind = cjt_set_flags(s_next.ind, 4'hA);
          end
          s_next.cc = s_reg.cc + cjt_pkg::INSTR_STEP;
        end else if (cur_op == cjt_pkg::OP_JC) begin
          // Save and restore: first character holds 33-38, second holds 39-40 in its low bits
          if (s_reg.step == 7'h00) begin
            s_next.step = 7'h01;
            s_next.mem_addr = s_reg.ea + 15'h0001;
            if (s_reg.instr[5:0] == cjt_pkg::SEL_SAVE) begin
              s_next.state = cjt_pkg::CJT_WRITE;
              s_next.mem_wr = 1'b1;
              s_next.mem_wdata = {4'h0, s_reg.ind[8:7]};
            end else begin
              s_next.ind[6:1] = mem_rdata_in;
              s_next.state = cjt_pkg::CJT_READ;
              s_next.mem_rd = 1'b1;
            end
          end else begin
            if (s_reg.instr[5:0] == cjt_pkg::SEL_RESTORE) begin
              s_next.ind[8:7] = mem_rdata_in[1:0];
            end
            s_next.cc = s_reg.cc + cjt_pkg::INSTR_STEP;
          end
        end else if (cur_op == cjt_pkg::OP_JR) begin
          // Address field spans low half of char 1 and all of chars 2 and 3
          s_next.step = s_reg.step + 7'h01;
          s_next.state = cjt_pkg::CJT_WRITE;
          s_next.mem_wr = 1'b1;
          if (s_reg.step == 7'h00) begin
            s_next.mem_wdata = {mem_rdata_in[5:3], ret_addr[14:12]};
          end else if (s_reg.step == 7'h01) begin
            s_next.mem_addr = s_reg.ea + 15'h0002;
            s_next.mem_wdata = ret_addr[11:6];
          end else if (s_reg.step == 7'h02) begin
            s_next.mem_addr = s_reg.ea + 15'h0003;
            s_next.mem_wdata = ret_addr[5:0];
          end else begin
            s_next.state = cjt_pkg::CJT_IDLE;
            s_next.mem_wr = 1'b0;
            s_next.cc = s_reg.ea + cjt_pkg::INSTR_STEP;
          end
        end else if (cur_op == cjt_pkg::OP_JL) begin
          // Indicators and accumulators are left alone by the loop jump
          s_next.cc = s_reg.taken ? s_reg.ea : ret_addr;
        end else if (cur_op == cjt_pkg::OP_TR) begin
          if (s_reg.phase == 2'h0) begin
            s_next.phase = 2'h1;
            s_next.state = cjt_pkg::CJT_READ;
            s_next.mem_rd = 1'b1;
            s_next.mem_addr = {3'h0, table_row_select_in, mem_rdata_in};
          end else if (s_reg.phase == 2'h1) begin
            s_next.phase = 2'h2;
            s_next.state = cjt_pkg::CJT_WRITE;
            s_next.mem_wr = 1'b1;
            s_next.mem_addr = tr_addr;
            s_next.mem_wdata = mem_rdata_in;
          end else if (s_reg.step + 7'h01 == tr_count) begin
            s_next.cc = ret_addr;
          end else begin
            s_next.step = s_reg.step + 7'h01;
            s_next.phase = 2'h0;
            s_next.state = cjt_pkg::CJT_READ;
            s_next.mem_rd = 1'b1;
            s_next.mem_addr = tr_addr - 15'h0001;
          end
        end else begin
          s_next.cc = ret_addr;
        end
      end

      default: begin
        s_next.state = cjt_pkg::CJT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '{
        state: cjt_pkg::CJT_IDLE,
        ind: cjt_pkg::IND_RST,
        cc: cjt_pkg::CC_RST,
        default: '0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    bus_rdata_out = s_reg.bus_rdata;
    mem_addr_out = s_reg.mem_addr;
    mem_rd_out = s_reg.mem_rd;
    mem_wr_out = s_reg.mem_wr;
    mem_wdata_out = s_reg.mem_wdata;
    tetrad_sel_out = s_reg.instr[5:0];
    busy_out = (s_reg.state != cjt_pkg::CJT_IDLE);
  end
endmodule

/* File: test/cjt_mem_model.sv */
`timescale 1ns/1ps
module cjt_mem_model (
  // Clock
  input wire logic clock_in,
  // Access
  input wire logic [14:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [5:0] wdata_in,
  output logic [5:0] rdata_out
);
  logic [5:0] mem_q [0:32767];
  initial rdata_out = 6'h00;
  // Toggles outside the answer cycle so a late sample never sees old data
  always @(posedge clock_in) begin
    if (wr_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    rdata_out <= rd_in ? mem_q[addr_in] : ~rdata_out;
  end
endmodule

/* File: test/cjt_checker.sv */
`timescale 1ns/1ps
module cjt_checker (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [31:0] bus_rdata_out,
  input wire logic [14:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [5:0] mem_wdata_out,
  input wire logic [5:0] mem_rdata_in,
  input wire logic [5:0] tetrad_sel_out,
  input wire logic [23:0] tetrad_data_in,
  input wire logic [5:0] table_row_select_in,
  input wire logic busy_out
);
  logic go;
  logic st;
  logic [5:0] op;
  logic [5:0] fld;
  logic [14:0] m_reg;
  assign op = {bus_wdata_in[29:25], 1'b0};
  assign fld = bus_wdata_in[5:0];
  // Only unindexed starts are judged, except by the no-operation check, so the target is the raw address field
  assign st = bus_wr_in && bus_addr_in == cjt_pkg::REG_INSTR && !busy_out;
  assign go = st && bus_wdata_in[24:22] == 3'h0;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      m_reg <= 15'h0000;
    end else if (go) begin
      m_reg <= bus_wdata_in[20:6];
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence s_rd(logic [14:0] a);
    mem_rd_out && mem_addr_out == a;
  endsequence
  sequence s_wr(logic [14:0] a);
    mem_wr_out && mem_addr_out == a;
  endsequence
  property p_ct;
    go && op == cjt_pkg::OP_CT |=> s_rd(m_reg) ##2 s_rd(m_reg + 15'h0001) ##2 s_rd(m_reg + 15'h0002)
      ##2 s_rd(m_reg + 15'h0003);
  endproperty
  a_ct: assert property (p_ct) else $error("tetrad compare read order wrong");
  property p_lc;
    go && op == cjt_pkg::OP_LC |=> s_rd(m_reg);
  endproperty
  a_lc: assert property (p_lc) else $error("masked compare address wrong");
  property p_save;
    go && op == cjt_pkg::OP_JC && fld == cjt_pkg::SEL_SAVE |=> s_wr(m_reg) ##2 s_wr(m_reg + 15'h0001);
  endproperty
  a_save: assert property (p_save) else $error("indicator save writes wrong");
  property p_jl;
    go && op == cjt_pkg::OP_JL |=> mem_wr_out && mem_wdata_out == (($past(fld) == 6'h00) ? 6'h00 : $past(fld) - 6'h01);
  endproperty
  a_jl: assert property (p_jl) else $error("loop count write back wrong");
  property p_tr;
    go && op == cjt_pkg::OP_TR |=> s_rd(m_reg) ##2
      (mem_rd_out && mem_addr_out == {3'h0, table_row_select_in, $past(mem_rdata_in)});
  endproperty
  a_tr: assert property (p_tr) else $error("table address wrong");
  property p_trw;
    go && op == cjt_pkg::OP_TR && fld != 6'h01 |=> ##4 s_wr(m_reg) ##2 s_rd(m_reg - 15'h0001);
  endproperty
  a_trw: assert property (p_trw) else $error("substitution walk wrong");
  property p_jr;
    go && op == cjt_pkg::OP_JR && fld < 6'h20 |=> s_rd(m_reg + 15'h0001) ##2 s_wr(m_reg + 15'h0001)
      ##2 s_wr(m_reg + 15'h0002) ##2 s_wr(m_reg + 15'h0003);
  endproperty
  a_jr: assert property (p_jr) else $error("return jump store wrong");
  property p_nop;
    st && op == cjt_pkg::OP_JC && (fld == cjt_pkg::SEL_NOP_A || fld == cjt_pkg::SEL_NOP_B)
      |=> (!busy_out && !mem_rd_out && !mem_wr_out) [*3];
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation selector acted");
endmodule
bind cjt_unit cjt_checker chk (.clock_in, .resetn_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in,
  .bus_rdata_out, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out, .mem_rdata_in, .tetrad_sel_out,
  .tetrad_data_in, .table_row_select_in, .busy_out);

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] bus_addr_in = 8'h00;
  logic [31:0] bus_wdata_in = 32'h0000_0000;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  logic [31:0] bus_rdata_out;
  logic [14:0] mem_addr_out;
  logic mem_rd_out;
  logic mem_wr_out;
  logic [5:0] mem_wdata_out;
  logic [5:0] mem_rdata_in;
  logic [5:0] tetrad_sel_out;
  logic [23:0] tetrad_data_in = 24'h00_0000;
  logic [5:0] table_row_select_in = 6'h01;
  logic busy_out;
  logic [31:0] rv;
  int n_errors = 0;
  int num_checks = 0;
  always #2.5 clock_in = ~clock_in;
  cjt_unit dut (.clock_in, .resetn_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out,
    .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out, .mem_rdata_in, .tetrad_sel_out, .tetrad_data_in,
    .table_row_select_in, .busy_out);
  cjt_mem_model mem (.clock_in, .addr_in(mem_addr_out), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
    .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cm(input logic [14:0] a, input logic [5:0] e);
    chk("mem", {26'h0, e}, {26'h0, mem.mem_q[a]});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_wr_in <= 1'b1;
    @(posedge clock_in);
    bus_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    bus_addr_in <= a;
    bus_rd_in <= 1'b1;
    @(posedge clock_in);
    bus_rd_in <= 1'b0;
    #1 rv = bus_rdata_out;
  endtask
  task automatic run(input logic [5:0] op, input logic [2:0] x, input logic [14:0] m, input logic [5:0] f);
    int i;
    wr(cjt_pkg::REG_INSTR, {2'b00, op[5:1], x, 1'b0, m, f});
    #1;
    for (i = 0; i < 2000 && busy_out !== 1'b0; i++) begin
      @(posedge clock_in);
      #1;
    end
    if (busy_out !== 1'b0) begin
      n_errors++;
      $display("CHECK FAILED busy expected 0 seen %b", busy_out);
    end
  endtask
  task automatic t_ct();
    logic [23:0] tv [3] = '{24'h7F_FFFF, 24'h80_0001, 24'hFF_FFFF};
    logic [3:0] fl [3] = '{4'b0011, 4'b0100, 4'b1010};
    @(posedge clock_in);
    mem.mem_q[100] = 6'h20;
    mem.mem_q[101] = 6'h00;
    mem.mem_q[102] = 6'h00;
    mem.mem_q[103] = 6'h01;
    rd(cjt_pkg::REG_IND);
    chk("reset ind", 32'h0000_0000, rv);
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_in);
      tetrad_data_in <= tv[k];
      wr(cjt_pkg::REG_CC, 32'h0000_0000);
      run(cjt_pkg::OP_CT, 3'h0, 15'h0064, 6'h17);
      chk("tetrad sel", 32'h0000_0017, {26'h0, tetrad_sel_out});
      rd(cjt_pkg::REG_IND);
      chk("ct flags", {28'h0, fl[k]}, {28'h0, rv[1], rv[2], rv[3], rv[4]});
      rd(cjt_pkg::REG_CC);
      chk("ct cc", 32'h0000_0005, rv);
    end
    $display("ct done");
  endtask
  task automatic t_lc();
    @(posedge clock_in);
    mem.mem_q[200] = 6'h0F;
    run(cjt_pkg::OP_LC, 3'h0, 15'h00C8, 6'h0B);
    rd(cjt_pkg::REG_IND);
    chk("lc equal", 32'h0000_0004, rv & 32'h0000_001E);
    run(cjt_pkg::OP_LC, 3'h0, 15'h00C8, 6'h10);
    rd(cjt_pkg::REG_IND);
    chk("lc high", 32'h0000_000A, rv & 32'h0000_001E);
    $display("lc done");
  endtask
  task automatic jc(input logic [5:0] s, input logic [31:0] iv, input logic [14:0] ec, input logic [31:0] ei);
    wr(cjt_pkg::REG_CC, 32'h0000_0000);
    wr(cjt_pkg::REG_IND, iv);
    run(cjt_pkg::OP_JC, 3'h1, 15'h0064, s);
    rd(cjt_pkg::REG_CC);
    chk("jc cc", {17'h0, ec}, rv);
    rd(cjt_pkg::REG_IND);
    chk("jc ind", ei, rv);
  endtask
  task automatic t_jc();
    wr(8'h24, 32'h0000_0007);
    rd(8'h24);
    chk("index one", 32'h0000_0007, rv);
    jc(6'h05, 32'h0000_0000, 15'h006B, 32'h0000_0000);
    jc(6'h20, 32'h0000_0002, 15'h0005, 32'h0000_0002);
    jc(6'h21, 32'h0000_0002, 15'h006B, 32'h0000_0002);
    jc(6'h22, 32'h0000_0002, 15'h0005, 32'h0000_0002);
    jc(6'h28, 32'h0000_0100, 15'h006B, 32'h0000_0000);
    jc(6'h2C, 32'h0000_1000, 15'h006B, 32'h0000_0000);
    jc(6'h39, 32'h0200_0000, 15'h006B, 32'h0000_0000);
    jc(6'h38, 32'hFFFF_FFFF, 15'h0005, 32'hFFFF_FFFF);
    $display("jc done");
  endtask
  task automatic t_save();
    wr(cjt_pkg::REG_CC, 32'h0000_0000);
    wr(cjt_pkg::REG_IND, 32'h0000_0154);
    run(cjt_pkg::OP_JC, 3'h0, 15'h012C, cjt_pkg::SEL_SAVE);
    wr(cjt_pkg::REG_IND, 32'h0000_0000);
    run(cjt_pkg::OP_JC, 3'h0, 15'h012C, cjt_pkg::SEL_RESTORE);
    rd(cjt_pkg::REG_IND);
    chk("restored ind", 32'h0000_0154, rv);
    rd(cjt_pkg::REG_CC);
    chk("save cc", 32'h0000_000A, rv);
    $display("save done");
  endtask
  task automatic t_jl();
    logic [5:0] nv [4] = '{6'h00, 6'h01, 6'h02, 6'h3F};
    for (int k = 0; k < 4; k++) begin
      wr(cjt_pkg::REG_CC, 32'h0000_0000);
      run(cjt_pkg::OP_JL, 3'h0, 15'h00C8, nv[k]);
      cm(15'h0004, (nv[k] < 6'h02) ? 6'h00 : nv[k] - 6'h01);
      rd(cjt_pkg::REG_CC);
      chk("jl cc", (nv[k] < 6'h02) ? 32'h0000_0005 : 32'h0000_00C8, rv);
      rd(cjt_pkg::REG_STATUS);
      chk("jl status", (nv[k] < 6'h02) ? 32'h0000_0000 : 32'h0000_0002, rv);
    end
    $display("jl done");
  endtask
  task automatic t_jr();
    @(posedge clock_in);
    mem.mem_q[401] = 6'h3F;
    wr(cjt_pkg::REG_CC, 32'h0000_000A);
    run(cjt_pkg::OP_JR, 3'h0, 15'h0190, 6'h00);
    cm(15'h0191, 6'h38);
    cm(15'h0192, 6'h00);
    cm(15'h0193, 6'h0F);
    rd(cjt_pkg::REG_CC);
    chk("jr cc", 32'h0000_0195, rv);
    $display("jr done");
  endtask
  task automatic t_tr();
    @(posedge clock_in);
    for (int k = 0; k < 64; k++) mem.mem_q[64 + k] = 6'(k) ^ 6'h2A;
    mem.mem_q[500] = 6'h03;
    mem.mem_q[499] = 6'h0A;
    mem.mem_q[498] = 6'h3F;
    mem.mem_q[497] = 6'h11;
    run(cjt_pkg::OP_TR, 3'h0, 15'h01F4, 6'h03);
    cm(15'h01F4, 6'h29);
    cm(15'h01F3, 6'h20);
    cm(15'h01F2, 6'h15);
    cm(15'h01F1, 6'h11);
    rd(8'h10);
    chk("unmapped", 32'h0000_0000, rv);
    $display("tr done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_ct();
    t_lc();
    t_jc();
    t_save();
    t_jl();
    t_jr();
    t_tr();
    results();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    results();
  end
endmodule
